// >>> logic/line_sup_pkg.sv
package line_sup_pkg;

  // Clock and time base
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int CAD_UNIT_MS = 10;
  localparam int NCH = 2;

  // Register index (byte address = index * 4 + channel * stride)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_SUPV = 3'h1;
  localparam logic [2:0] REG_RING = 3'h2;
  localparam logic [2:0] REG_CAD = 3'h3;
  localparam logic [2:0] REG_STAT = 3'h4;
  localparam logic [2:0] REG_EVT = 3'h5;
  localparam logic [2:0] REG_MASK = 3'h6;
  localparam logic [2:0] REG_TDB = 3'h7;
  localparam logic [7:0] CH_STRIDE = 8'h20;

  // Control fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_ZXR = 1;
  localparam int CTRL_AC = 2;
  localparam int CTRL_TDC = 3;
  localparam int CTRL_ACT = 4;
  localparam int CTRL_RATE = 5;

  // Supervision fields
  localparam int SUPV_TSH = 0;
  localparam int SUPV_DSH = 3;
  localparam int SUPV_TGK = 8;
  localparam int SUPV_DGK = 11;

  // Ring trip fields
  localparam int RING_TRIP_CURRENT_THRESHOLD = 0;
  localparam int RING_ILR = 8;

  // Cadence fields, 10 ms units
  localparam int CAD_ON = 0;
  localparam int CAD_OFF = 8;

  // Event bits
  localparam int EV_HOOK = 0;
  localparam int EV_GK = 1;
  localparam int EV_TRIP = 2;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0004;
  localparam logic [15:0] SUPV_RST = 16'h0000;
  localparam logic [15:0] RING_RST = 16'h0000;
  localparam logic [15:0] CAD_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;

  // Current scales, units of 0.5 mA
  localparam logic [7:0] HOOK_THR_BASE = 8'h10;
  localparam logic [7:0] GK_THR_STEP = 8'h0c;
  localparam logic [7:0] ILR_BASE = 8'h64;
  localparam logic [7:0] NEAR_LIMIT = 8'h04;

  // Debounce scales, ms
  localparam logic [5:0] HOOK_DEB_MIN = 6'h0c;
  localparam logic [5:0] GK_DEB_MIN = 6'h04;

  typedef enum logic [2:0] {
    CAD_IDLE,
    CAD_ENTRY,
    CAD_ON_ST,
    CAD_EXIT,
    CAD_OFF_ST
  } cad_state_t;

endpackage

// >>> logic/debounce_timer.sv
`timescale 1ns/1ps
module debounce_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic raw,
  input wire logic [5:0] limit,
  output logic state,
  output logic change
);
  logic raw_q;
  logic state_q;
  logic chg_q;
  logic [5:0] cnt_q;
  wire [5:0] cnt_inc = cnt_q + 6'h01;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      raw_q <= 1'b0;
      state_q <= 1'b0;
      chg_q <= 1'b0;
      cnt_q <= 6'h00;
    end
    else
    begin
      raw_q <= raw;
      chg_q <= 1'b0;
      if (raw != raw_q)
        cnt_q <= 6'h00;
      else if (raw == state_q)
        cnt_q <= 6'h00;
      else if (tick)
      begin
        if (cnt_inc >= limit)
        begin
          state_q <= raw;
          chg_q <= 1'b1;
          cnt_q <= 6'h00;
        end
        else
          cnt_q <= cnt_inc;
      end
    end
  end

  assign state = state_q;
  assign change = chg_q;
endmodule // debounce_timer

// >>> logic/line_supervision_ring_trip.sv
// Functional notes
// - Cadenced ringing exits on off-hook or ring-trip of that channel.
// - Zero-cross control at 0 makes ringing entry and exit smooth.
// - Smooth entry applies ringing within one ringing period.
// - Loop current compared with 3-bit threshold, 8 to 15 mA.
// - Hook comparator debounced by 5-bit timer, 12 to 62 ms.
// - Debounced hook change raises masked interrupt.
// - Capture mode with codec active samples hook every 1, 2, 4 or 8 ms.
// - Hook sample buffer holds six samples per channel.
// - Ground-key detector compares longitudinal current, 3-bit, 0 to 42 mA.
// - Ground-key comparator debounced by 5-bit timer, 4 to 31 ms.
// - Debounced ground-key change raises masked interrupt.
// - Over half a cycle near current limit gives trip indication.
// - Trip indications on two complete cycles declare ring trip.
// - AC-only mode: rectified cycle average over threshold twice sets hook.
// - Trip threshold in 0.5 mA steps, 0 to 63.5 mA.
// - Ringing current limit 50 mA plus 2 mA per code.
`timescale 1ns/1ps
module line_supervision_ring_trip #(
  parameter int MS_CYCLES = line_sup_pkg::MS_CYCLES,
  parameter int TDB_DEPTH = 6
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] loop_cur,
  input wire logic [15:0] long_cur,
  input wire logic [17:0] ring_cur,
  input wire logic adc_valid,
  input wire logic [1:0] ring_cycle_end,
  input wire logic [1:0] ring_zero_cross,
  output logic [1:0] ring_apply,
  output logic irq
);
  localparam int MSW = $clog2(MS_CYCLES);

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [MSW-1:0] ms_cnt_q;
  logic ms_tick_q;
  logic [3:0] cad_cnt_q;
  logic cad_tick_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic irq_q;
  logic [15:0] rd_word [2];
  logic [1:0] irq_ch;
  logic [1:0] apply_ch;

  // Reset release
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Millisecond and cadence ticks
  wire ms_wrap = (ms_cnt_q == MSW'(MS_CYCLES - 1));
  wire cad_wrap = (cad_cnt_q == 4'(line_sup_pkg::CAD_UNIT_MS - 1));
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_cnt_q <= '0;
      ms_tick_q <= 1'b0;
      cad_cnt_q <= 4'h0;
      cad_tick_q <= 1'b0;
    end
    else
    begin
      ms_cnt_q <= ms_wrap ? '0 : ms_cnt_q + MSW'(1);
      ms_tick_q <= ms_wrap;
      cad_tick_q <= ms_tick_q & cad_wrap;
      if (ms_tick_q)
        cad_cnt_q <= cad_wrap ? 4'h0 : cad_cnt_q + 4'h1;
    end
  end

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire mapped = (wb_adr_i[7:6] == 2'h0);
  wire ch_sel = wb_adr_i[5];
  wire [2:0] reg_sel = wb_adr_i[4:2];
  wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] wdat = wb_dat_i[15:0];
  wire [31:0] rdata_d = mapped ? {16'h0000, rd_word[ch_sel]} : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      ack_q <= req;
      if (req && !wb_we_i)
        dat_q <= rdata_d;
      irq_q <= |irq_ch;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq = irq_q;
  assign ring_apply = apply_ch;

  genvar ch;
  generate
    for (ch = 0; ch < line_sup_pkg::NCH; ch++)
    begin : g_ch
      logic [15:0] ctrl_q;
      logic [15:0] supv_q;
      logic [15:0] ring_q;
      logic [15:0] cad_q;
      logic [15:0] mask_q;
      logic [2:0] evt_q;
      logic hook_deb;
      logic hook_chg;
      logic gk_deb;
      logic gk_chg;
      logic [19:0] acc_i_q;
      logic [19:0] acc_t_q;
      logic [11:0] n_q;
      logic [11:0] dcn_q;
      logic [11:0] limn_q;
      logic prev_q;
      logic trip_q;
      line_sup_pkg::cad_state_t cad_st_q;
      line_sup_pkg::cad_state_t cad_d;
      logic [7:0] tmr_q;
      logic apply_q;
      logic [3:0] smp_cnt_q;
      logic [TDB_DEPTH-1:0] tdb_q;
      logic [2:0] tdb_n_q;

      wire sel_me = req & mapped & (ch_sel == 1'(ch));
      wire wr = sel_me & wb_we_i;
      wire rd_tdb = sel_me & ~wb_we_i & (reg_sel == line_sup_pkg::REG_TDB);
      wire run = ctrl_q[line_sup_pkg::CTRL_RUN];
      wire zero_cross_ring_ctrl = ctrl_q[line_sup_pkg::CTRL_ZXR];
      wire ac_only = ctrl_q[line_sup_pkg::CTRL_AC];
      wire capture = ctrl_q[line_sup_pkg::CTRL_TDC] &
                     ctrl_q[line_sup_pkg::CTRL_ACT];
      wire [1:0] rate = ctrl_q[line_sup_pkg::CTRL_RATE +: 2];
      wire [2:0] offhook_threshold = supv_q[line_sup_pkg::SUPV_TSH +: 3];
      wire [4:0] offhook_debounce_time = supv_q[line_sup_pkg::SUPV_DSH +: 5];
      wire [2:0] gndkey_threshold = supv_q[line_sup_pkg::SUPV_TGK +: 3];
      wire [4:0] gndkey_debounce_time = supv_q[line_sup_pkg::SUPV_DGK +: 5];
      wire [6:0] trip_current_threshold = ring_q[line_sup_pkg::RING_TRIP_CURRENT_THRESHOLD +: 7];
      wire [4:0] ringing_current_limit = ring_q[line_sup_pkg::RING_ILR +: 5];
      wire [7:0] on_t = cad_q[line_sup_pkg::CAD_ON +: 8];
      wire [7:0] off_t = cad_q[line_sup_pkg::CAD_OFF +: 8];
      wire [7:0] loop_i = loop_cur[ch*8 +: 8];
      wire [7:0] long_i = long_cur[ch*8 +: 8];
      wire [8:0] ring_i = ring_cur[ch*9 +: 9];
      wire cend = ring_cycle_end[ch];
      wire zc = ring_zero_cross[ch];

      wire [7:0] hook_thr = line_sup_pkg::HOOK_THR_BASE + {4'h0, offhook_threshold, 1'b0};
      wire hook_raw = (loop_i >= hook_thr);
      wire [7:0] gk_thr = 8'({5'h00, gndkey_threshold} * line_sup_pkg::GK_THR_STEP);
      wire gk_raw = (long_i > gk_thr);
      wire [5:0] dsh_ms = {offhook_debounce_time, 1'b0};
      wire [5:0] dgk_ms = {1'b0, gndkey_debounce_time};
      wire [5:0] hook_lim = (dsh_ms < line_sup_pkg::HOOK_DEB_MIN) ?
                            line_sup_pkg::HOOK_DEB_MIN : dsh_ms;
      wire [5:0] gk_lim = (dgk_ms < line_sup_pkg::GK_DEB_MIN) ?
                          line_sup_pkg::GK_DEB_MIN : dgk_ms;

      debounce_timer u_hook (
        .clk(clk_sys),
        .rst_n(rst_n),
        .tick(ms_tick_q),
        .raw(hook_raw),
        .limit(hook_lim),
        .state(hook_deb),
        .change(hook_chg)
      );
      debounce_timer u_gk (
        .clk(clk_sys),
        .rst_n(rst_n),
        .tick(ms_tick_q),
        .raw(gk_raw),
        .limit(gk_lim),
        .state(gk_deb),
        .change(gk_chg)
      );

      wire [7:0] half = ring_i[8] ? 8'h00 : ring_i[7:0];
      wire [8:0] neg = 9'h000 - ring_i;
      wire [7:0] mag = ring_i[8] ? (neg[8] ? 8'hff : neg[7:0]) : ring_i[7:0];
      wire [7:0] ilim = line_sup_pkg::ILR_BASE + {1'b0, ringing_current_limit, 2'h0};
      wire near_lim = (mag >= ilim - line_sup_pkg::NEAR_LIMIT);
      wire over = (half > {1'b0, trip_current_threshold});
      wire ac_ind = (acc_i_q > acc_t_q);
      wire dc_ind = ({dcn_q, 1'b0} > {1'b0, n_q});
      wire lim_ind = ({limn_q, 1'b0} > {1'b0, n_q});
      wire ind = (n_q != 12'h000) & ((ac_only ? ac_ind : dc_ind) | lim_ind);
      wire confirm = cend & ind & prev_q;
      wire trip_clr = wr & (reg_sel == line_sup_pkg::REG_CTRL) &
                      wmask[line_sup_pkg::CTRL_RUN] &
                      wdat[line_sup_pkg::CTRL_RUN];

      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          acc_i_q <= 20'h00000;
          acc_t_q <= 20'h00000;
          n_q <= 12'h000;
          dcn_q <= 12'h000;
          limn_q <= 12'h000;
          prev_q <= 1'b0;
        end
        else if (!apply_q || cend)
        begin
          acc_i_q <= 20'h00000;
          acc_t_q <= 20'h00000;
          n_q <= 12'h000;
          dcn_q <= 12'h000;
          limn_q <= 12'h000;
          prev_q <= apply_q & ind;
        end
        else if (adc_valid)
        begin
          acc_i_q <= acc_i_q + {12'h000, half};
          acc_t_q <= acc_t_q + {13'h0000, trip_current_threshold};
          n_q <= n_q + 12'h001;
          dcn_q <= dcn_q + {11'h000, over};
          limn_q <= limn_q + {11'h000, near_lim};
        end
      end

      // Trip flag, set wins over restart
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          trip_q <= 1'b0;
        else
          trip_q <= (apply_q & confirm) | (trip_q & ~trip_clr);
      end

      wire stop = hook_deb | trip_q;
      wire edge_ok = zero_cross_ring_ctrl | zc | cend;
      always_comb
      begin
        cad_d = cad_st_q;
        case (cad_st_q)
          line_sup_pkg::CAD_IDLE:
            if (run && !stop)
              cad_d = line_sup_pkg::CAD_ENTRY;
          line_sup_pkg::CAD_ENTRY:
            if (!run || stop)
              cad_d = line_sup_pkg::CAD_IDLE;
            else if (edge_ok)
              cad_d = line_sup_pkg::CAD_ON_ST;
          line_sup_pkg::CAD_ON_ST:
            if (!run || stop || (on_t != 8'h00 && tmr_q >= on_t))
              cad_d = line_sup_pkg::CAD_EXIT;
          line_sup_pkg::CAD_EXIT:
            if (edge_ok)
              cad_d = (!run || stop) ? line_sup_pkg::CAD_IDLE :
                      line_sup_pkg::CAD_OFF_ST;
          line_sup_pkg::CAD_OFF_ST:
            if (!run || stop)
              cad_d = line_sup_pkg::CAD_IDLE;
            else if (tmr_q >= off_t)
              cad_d = line_sup_pkg::CAD_ENTRY;
          default:
            cad_d = line_sup_pkg::CAD_IDLE;
        endcase
      end

      wire abort = stop & (cad_st_q != line_sup_pkg::CAD_IDLE);
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cad_st_q <= line_sup_pkg::CAD_IDLE;
          tmr_q <= 8'h00;
          apply_q <= 1'b0;
        end
        else
        begin
          cad_st_q <= cad_d;
          if (cad_d != cad_st_q)
            tmr_q <= 8'h00;
          else if (cad_tick_q && tmr_q != 8'hff)
            tmr_q <= tmr_q + 8'h01;
          apply_q <= (cad_d == line_sup_pkg::CAD_ON_ST) ||
                     (cad_d == line_sup_pkg::CAD_EXIT);
        end
      end

      // Register writes; abort drops the run request
      wire wr_ctrl = wr & (reg_sel == line_sup_pkg::REG_CTRL);
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          ctrl_q <= line_sup_pkg::CTRL_RST;
          supv_q <= line_sup_pkg::SUPV_RST;
          ring_q <= line_sup_pkg::RING_RST;
          cad_q <= line_sup_pkg::CAD_RST;
          mask_q <= line_sup_pkg::MASK_RST;
        end
        else
        begin
          if (wr_ctrl)
            ctrl_q <= (ctrl_q & ~wmask) | (wdat & wmask);
          else if (abort)
            ctrl_q[line_sup_pkg::CTRL_RUN] <= 1'b0;
          if (wr && reg_sel == line_sup_pkg::REG_SUPV)
            supv_q <= (supv_q & ~wmask) | (wdat & wmask);
          if (wr && reg_sel == line_sup_pkg::REG_RING)
            ring_q <= (ring_q & ~wmask) | (wdat & wmask);
          if (wr && reg_sel == line_sup_pkg::REG_CAD)
            cad_q <= (cad_q & ~wmask) | (wdat & wmask);
          if (wr && reg_sel == line_sup_pkg::REG_MASK)
            mask_q <= (mask_q & ~wmask) | (wdat & wmask);
        end
      end

      // sticky events, set wins over clear
      wire [2:0] evt_set = {confirm & apply_q & ~trip_q, gk_chg, hook_chg};
      wire [2:0] evt_clr = (wr && reg_sel == line_sup_pkg::REG_EVT) ?
                           (wdat[2:0] & wmask[2:0]) : 3'h0;
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          evt_q <= 3'h0;
        else
          evt_q <= (evt_q & ~evt_clr) | evt_set;
      end
      assign irq_ch[ch] = |(evt_q & mask_q[2:0]);

      wire [3:0] smp_per = 4'h1 << rate;
      wire smp_now = capture & ms_tick_q & (smp_cnt_q + 4'h1 >= smp_per);
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          smp_cnt_q <= 4'h0;
          tdb_q <= '0;
          tdb_n_q <= 3'h0;
        end
        else
        begin
          if (!capture || smp_now)
            smp_cnt_q <= 4'h0;
          else if (ms_tick_q)
            smp_cnt_q <= smp_cnt_q + 4'h1;
          if (smp_now)
          begin
            tdb_q <= {tdb_q[TDB_DEPTH-2:0], hook_deb | trip_q};
            if (rd_tdb)
              tdb_n_q <= 3'h1;
            else if (tdb_n_q != 3'(TDB_DEPTH))
              tdb_n_q <= tdb_n_q + 3'h1;
          end
          else if (rd_tdb)
            tdb_n_q <= 3'h0;
        end
      end

      // Read mux
      wire [15:0] stat = {12'h000, apply_q, trip_q, gk_deb, hook_deb | trip_q};
      wire [15:0] tdb_w = {5'h00, tdb_n_q, 2'h0, 6'(tdb_q)};
      assign rd_word[ch] =
        (reg_sel == line_sup_pkg::REG_CTRL) ? ctrl_q :
        (reg_sel == line_sup_pkg::REG_SUPV) ? supv_q :
        (reg_sel == line_sup_pkg::REG_RING) ? ring_q :
        (reg_sel == line_sup_pkg::REG_CAD) ? cad_q :
        (reg_sel == line_sup_pkg::REG_STAT) ? stat :
        (reg_sel == line_sup_pkg::REG_EVT) ? {13'h0000, evt_q} :
        (reg_sel == line_sup_pkg::REG_MASK) ? mask_q : tdb_w;
      assign apply_ch[ch] = apply_q;
    end
  endgenerate
endmodule // line_supervision_ring_trip

// >>> bench/line_sup_assertions.sv
`timescale 1ns/1ps
module line_sup_assertions (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] ring_cycle_end,
  input wire logic [1:0] ring_zero_cross,
  input wire logic [1:0] ring_apply,
  input wire logic irq
);
  logic req;
  logic edge0;
  logic zxr_q;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign edge0 = ring_zero_cross[0] || ring_cycle_end[0];
  // Shadow of channel 0 zero-cross control
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      zxr_q <= 1'b0;
    else if (req && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0])
      zxr_q <= wb_dat_i[1];
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  property p_ack_reply;
    req |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_hi_zero;
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
  endproperty
  property p_unmapped;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[7:6]) != 2'b00
      |-> wb_dat_o == 32'h0000_0000;
  endproperty
  property p_dat_hold;
    $changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i);
  endproperty
  property p_entry;
    $rose(ring_apply[0]) && !zxr_q
      |-> $past(edge0, 1) || $past(edge0, 2) || $past(edge0, 3);
  endproperty
  property p_exit;
    $fell(ring_apply[0]) && !zxr_q
      |-> $past(edge0, 1) || $past(edge0, 2) || $past(edge0, 3);
  endproperty
  property p_irq_fall;
    $fell(irq) |-> $past(wb_cyc_i && wb_we_i, 1)
      || $past(wb_cyc_i && wb_we_i, 2);
  endproperty
  a_ack_reply: assert property (p_ack_reply)
    else $error("ack missing after request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_hi_zero: assert property (p_hi_zero)
    else $error("upper read bits not zero");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data changed without read");
  a_entry: assert property (p_entry)
    else $error("ringing applied off a zero cross");
  a_exit: assert property (p_exit)
    else $error("ringing removed off a zero cross");
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq dropped without a write");
  c_ring_on: cover property ($rose(ring_apply[0]));
  c_ring_off: cover property ($fell(ring_apply[0]));
  c_irq: cover property ($rose(irq));
endmodule // line_sup_assertions

bind line_supervision_ring_trip line_sup_assertions u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ring_cycle_end(ring_cycle_end),
  .ring_zero_cross(ring_zero_cross), .ring_apply(ring_apply), .irq(irq)
);

// >>> bench/line_front_end.sv
`timescale 1ns/1ps
module line_front_end #(
  parameter int PER = 32
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [1:0] ring_apply,
  input wire logic [17:0] ring_lvl,
  output logic [17:0] ring_cur,
  output logic adc_valid,
  output logic [1:0] ring_cycle_end,
  output logic [1:0] ring_zero_cross
);
  logic [7:0] cnt_q;
  // Free running ringing generator period
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= 8'h00;
    else
      cnt_q <= (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
  end
  assign ring_cycle_end = {2{cnt_q == 8'(PER - 1)}};
  assign ring_zero_cross = {2{cnt_q == 8'(PER / 2)}};
  assign adc_valid = cnt_q[1:0] == 2'b01;
  // Current flows only while ringing is applied
  assign ring_cur[8:0] = ring_apply[0] ? ring_lvl[8:0] : 9'h000;
  assign ring_cur[17:9] = ring_apply[1] ? ring_lvl[17:9] : 9'h000;
endmodule // line_front_end

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int MS = 20;
  localparam int PER = 32;
  logic clk_sys, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic adc_valid, irq;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] loop_cur, long_cur;
  logic [17:0] ring_cur, ring_lvl;
  logic [1:0] ring_cycle_end, ring_zero_cross, ring_apply;
  int err_count, tests_run;

  line_supervision_ring_trip #(.MS_CYCLES(MS), .TDB_DEPTH(6)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .loop_cur(loop_cur), .long_cur(long_cur),
    .ring_cur(ring_cur), .adc_valid(adc_valid),
    .ring_cycle_end(ring_cycle_end), .ring_zero_cross(ring_zero_cross),
    .ring_apply(ring_apply), .irq(irq));
  line_front_end #(.PER(PER)) fe (
    .clk_sys(clk_sys), .arst_n(arst_n), .ring_apply(ring_apply),
    .ring_lvl(ring_lvl), .ring_cur(ring_cur), .adc_valid(adc_valid),
    .ring_cycle_end(ring_cycle_end), .ring_zero_cross(ring_zero_cross));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic hang();
    err_count++;
    print_verdict();
  endtask

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb_cycle(input logic we, input logic [7:0] adr,
                          input logic [15:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0000, dat};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    if (wb_ack_o !== 1'b1)
      hang();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_ms(input int n);
    repeat (n * MS) @(posedge clk_sys);
  endtask

  task automatic wait_apply(input logic v, input int lim);
    int n;
    n = 0;
    while (ring_apply[0] !== v && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (ring_apply[0] !== v)
      hang();
  endtask

  initial
  begin
    err_count = 0;
    tests_run = 0;
    arst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0;
    loop_cur = 16'h0000;
    long_cur = 16'h0000;
    ring_lvl = 18'h00000;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Reset values of both channels
    for (int a = 0; a < 64; a += 4)
    begin
      wb_cycle(1'b0, 8'(a), 16'h0000);
      check("reset value", (a % 32 == 0) ? 32'h4 : 32'h0, rd);
    end
    wb_cycle(1'b1, 8'h40, 16'hffff);
    wb_cycle(1'b0, 8'h40, 16'h0000);
    check("unmapped", 32'h0, rd);
    wb_cycle(1'b1, 8'h28, 16'h1f7f);
    wb_cycle(1'b0, 8'h28, 16'h0000);
    check("ring limits", 32'h1f7f, rd);
    // Off-hook on channel 0, 12 ms debounce
    loop_cur <= 16'h0014;
    wait_ms(5);
    loop_cur <= 16'h0000;
    wait_ms(5);
    wb_cycle(1'b0, 8'h10, 16'h0000);
    check("hook glitch", 32'h0, rd);
    loop_cur <= 16'h0014;
    wait_ms(8);
    wb_cycle(1'b0, 8'h10, 16'h0000);
    check("hook early", 32'h0, rd);
    wait_ms(6);
    wb_cycle(1'b0, 8'h10, 16'h0000);
    check("hook", 32'h1, rd);
    wb_cycle(1'b0, 8'h30, 16'h0000);
    check("hook ch1", 32'h0, rd);
    wb_cycle(1'b0, 8'h14, 16'h0000);
    check("hook event", 32'h1, rd);
    check("irq masked", 32'h0, {31'h0, irq});
    wb_cycle(1'b1, 8'h18, 16'h0001);
    check("irq", 32'h1, {31'h0, irq});
    wb_cycle(1'b1, 8'h14, 16'h0001);
    check("irq cleared", 32'h0, {31'h0, irq});
    wb_cycle(1'b1, 8'h04, 16'h0007);
    wait_ms(14);
    wb_cycle(1'b0, 8'h10, 16'h0000);
    check("hook threshold", 32'h0, rd);
    // Ground key on channel 1, 12 ms debounce
    wb_cycle(1'b1, 8'h24, 16'h6100);
    long_cur <= 16'h1000;
    wait_ms(8);
    wb_cycle(1'b0, 8'h30, 16'h0000);
    check("gk early", 32'h0, rd);
    wait_ms(12);
    wb_cycle(1'b0, 8'h30, 16'h0000);
    check("gk", 32'h2, rd);
    wb_cycle(1'b0, 8'h34, 16'h0000);
    check("gk event", 32'h2, rd);
    wb_cycle(1'b0, 8'h10, 16'h0000);
    check("gk ch0", 32'h0, rd);
    // Hook sample buffer on channel 1
    wb_cycle(1'b1, 8'h20, 16'h001c);
    wb_cycle(1'b0, 8'h3c, 16'h0000);
    wait_ms(9);
    wb_cycle(1'b0, 8'h3c, 16'h0000);
    check("sample buffer", 32'h0600, rd);
    // Ring trip on channel 0, AC-only average
    wb_cycle(1'b1, 8'h08, 16'h1f28);
    wb_cycle(1'b1, 8'h00, 16'h0005);
    wait_apply(1'b1, PER + 4);
    repeat (4 * PER) @(posedge clk_sys);
    check("no trip", 32'h1, {31'h0, ring_apply[0]});
    ring_lvl <= 18'h00040;
    repeat (PER / 2) @(posedge clk_sys);
    check("trip early", 32'h1, {31'h0, ring_apply[0]});
    wait_apply(1'b0, 4 * PER + 4);
    wb_cycle(1'b0, 8'h10, 16'h0000);
    check("trip status", 32'h5, rd);
    wb_cycle(1'b0, 8'h00, 16'h0000);
    check("run cleared", 32'h4, rd);
    // Near current limit trip after re-entry
    ring_lvl <= 18'h00070;
    wait_ms(100);
    wb_cycle(1'b1, 8'h08, 16'h007f);
    wb_cycle(1'b1, 8'h00, 16'h0005);
    wait_apply(1'b1, PER + 4);
    wait_apply(1'b0, 4 * PER + 4);
    wb_cycle(1'b0, 8'h10, 16'h0000);
    check("limit trip", 32'h5, rd);
    print_verdict();
  end
endmodule // testbench
